// [design/pcp_defs.svh]
// Offsets, field positions, reset values and constants of the conversion pipe
`ifndef PCP_DEFS_SVH
`define PCP_DEFS_SVH
`define PCP_OFF_CTRL 32'h0000_0000
`define PCP_OFF_SCALE 32'h0000_0004
`define PCP_OFF_FMT 32'h0000_0008
`define PCP_OFF_LUTADDR 32'h0000_000C
`define PCP_OFF_LUTDATA 32'h0000_0010
`define PCP_OFF_STATUS 32'h0000_0014
`define PCP_OFF_GEOM 32'h0000_0018
// CTRL fields
`define PCP_CTRL_FLIPX 0
`define PCP_CTRL_FLIPY 1
`define PCP_CTRL_BAYER_EN 2
`define PCP_CTRL_PHASE_LO 3
`define PCP_CTRL_PHASE_HI 4
`define PCP_CTRL_COLOR 5
`define PCP_CTRL_DEPTH_LO 6
`define PCP_CTRL_DEPTH_HI 7
`define PCP_CTRL_RESET 32'h0000_0000
`define PCP_SCALE_RESET 32'h0000_0000
`define PCP_FMT_RESET 32'h0000_0000
`define PCP_GEOM_RESET 32'h0001_0001
// Fixed-point colour coefficients, scaled by 256
`define PCP_KYB 10'h01D
`define PCP_KYG 10'h096
`define PCP_KYR 10'h04D
`define PCP_KUB 10'h080
`define PCP_KUG 10'h055
`define PCP_KUR 10'h02B
`define PCP_KVB 10'h015
`define PCP_KVG 10'h06B
`define PCP_KVR 10'h080
`define PCP_LUT_DEPTH 4096
`define PCP_LINE_MAX 2048
`endif

// [design/pcp_pkg.sv]
// Types shared by the conversion pipe files
package pcp_pkg;
  typedef enum logic [1:0] {
    PCP_D8 = 2'h0,
    PCP_D10 = 2'h1,
    PCP_D12 = 2'h2,
    PCP_DOTHER = 2'h3
  } pcp_depth_type;
  typedef enum logic [1:0] {
    PCP_SRC_MONO8 = 2'h0,
    PCP_SRC_MONO16 = 2'h1,
    PCP_SRC_BGR24 = 2'h2,
    PCP_SRC_BGR48 = 2'h3
  } pcp_src_type;
  typedef enum logic [2:0] {
    PCP_DST_SAME = 3'h0,
    PCP_DST_MONO = 3'h1,
    PCP_DST_BGR = 3'h2,
    PCP_DST_BGRA = 3'h3,
    PCP_DST_YUV = 3'h4
  } pcp_dst_type;
  typedef enum logic [1:0] {
    PCP_PH_GB = 2'h0,
    PCP_PH_BG = 2'h1,
    PCP_PH_GR = 2'h2,
    PCP_PH_RG = 2'h3
  } pcp_phase_type;
endpackage

// [design/pcp_mem.sv]
// Simple dual-port memory, one write port and one registered read port
`timescale 1ns/1ps
module pcp_mem #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 4096,
  parameter int AW = 12
) (
  input wire logic hclk,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [WIDTH-1:0] wdata,
  input wire logic [AW-1:0] raddr,
  output logic [WIDTH-1:0] rdata
);
  logic [WIDTH-1:0] mem [DEPTH];
  always_ff @(posedge hclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule

// [design/pcp_top.sv]
// Pixel conversion pipeline: acquisition lookup and output formatter
//
// Overview of operation
// - Acquisition lookup remaps 8, 10 or 12 bit mono or colour samples.
// - Lookup acts only on the link-to-memory path, at acquisition time.
// - Colour links use the same table for every band.
// - Any link at 12 bits forces one common table for all links.
// - Other depths pass unchanged, like an identity table.
// - Formatter processes every pixel on the memory-to-host path.
// - Independent horizontal and vertical subsampling, factor 1 to 16.
// - Subsampling keeps one source pixel, no averaging.
// - Optional horizontal mirroring; flipy only sets a line index, not the output.
// - Conversion chosen by source type and destination format.
// - Luma is 0.114B + 0.587G + 0.299R, shifted by depth minus 8.
// - U is 0.5B - 0.331G - 0.169R + half range, shifted.
// - V is -0.081B - 0.419G + 0.5R + half range, shifted.
// - Depth is 8 for 24-bit BGR and 16 for 48-bit BGR.
// - 48-bit sources computed at 16 bits, then shifted right by 8.
// - Optional Bayer stage follows the formatter output.
// - Bayer phases GB, BG, GR, RG demosaiced over a 2x2 window; green averaged, blue and red taken from one sample.
`timescale 1ns/1ps
`include "pcp_defs.svh"
module pcp_top (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [1:0] acq_link,
  input wire logic acq_valid,
  input wire logic [11:0] acq_data,
  output logic acq_out_valid,
  output logic [11:0] acq_out_data,
  output logic [1:0] acq_out_link,
  input wire logic mem_valid,
  input wire logic mem_sol,
  input wire logic mem_sof,
  input wire logic [47:0] mem_data,
  output logic dma_valid,
  output logic [47:0] dma_data
);
  import pcp_pkg::*;
  // ----------------------------------------------------------------
  // Register bus slave
  // ----------------------------------------------------------------
  logic [31:0] ctrl, scale, fmt, lut_addr, geom;
  logic [31:0] addr_q;
  logic wr_q;
  logic [4:0] lut_rd_cnt;
  logic [3:0] deep_links;
  wire take = hsel & hready & htrans[1];
  wire wr_ctrl = wr_q & (addr_q == `PCP_OFF_CTRL);
  wire wr_scale = wr_q & (addr_q == `PCP_OFF_SCALE);
  wire wr_fmt = wr_q & (addr_q == `PCP_OFF_FMT);
  wire wr_laddr = wr_q & (addr_q == `PCP_OFF_LUTADDR);
  wire wr_ldata = wr_q & (addr_q == `PCP_OFF_LUTDATA);
  wire wr_geom = wr_q & (addr_q == `PCP_OFF_GEOM);
  wire [1:0] acq_depth = ctrl[`PCP_CTRL_DEPTH_HI:`PCP_CTRL_DEPTH_LO];
  wire any12 = |deep_links;
  // Read decode runs in the address phase so data stands in the data phase
  wire [31:0] rd_addr = {haddr[31:2], 2'h0};
  wire [31:0] rd_mux =
    (rd_addr == `PCP_OFF_CTRL) ? ctrl :
    (rd_addr == `PCP_OFF_SCALE) ? scale :
    (rd_addr == `PCP_OFF_FMT) ? fmt :
    (rd_addr == `PCP_OFF_LUTADDR) ? lut_addr :
    (rd_addr == `PCP_OFF_GEOM) ? geom :
    (rd_addr == `PCP_OFF_STATUS) ? {27'h0, any12, deep_links} : 32'h0;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      addr_q <= 32'h0;
      wr_q <= 1'b0;
    end else begin
      wr_q <= take & hwrite;
      if (take) begin
        addr_q <= {haddr[31:2], 2'h0};
      end
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl <= `PCP_CTRL_RESET;
      scale <= `PCP_SCALE_RESET;
      fmt <= `PCP_FMT_RESET;
      lut_addr <= 32'h0;
      geom <= `PCP_GEOM_RESET;
    end else begin
      if (wr_ctrl) ctrl <= hwdata;
      if (wr_scale) scale <= hwdata;
      if (wr_fmt) fmt <= hwdata;
      if (wr_geom) geom <= hwdata;
      if (wr_laddr) begin
        lut_addr <= hwdata;
      end else if (wr_ldata) begin
        lut_addr <= lut_addr + 32'h1;
      end
    end
  end
  // Zero wait states; every transfer answers OKAY
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (take & ~hwrite) hrdata <= rd_mux;
    end
  end
  // ----------------------------------------------------------------
  // Acquisition lookup
  // ----------------------------------------------------------------
  // Table index: link in bits 11:10 unless any link runs 12 bits.
  // One table per link covers all its colour bands.
  logic [11:0] lut_q;
  logic [1:0] acq_link_d;
  logic acq_valid_d;
  logic [11:0] acq_data_d;
  logic [1:0] depth_d;
  wire [11:0] idx_sep = {acq_link, acq_data[9:0]};
  // A 12-bit link takes the whole table, so the mapping is shared.
  wire share = any12 | (acq_depth == PCP_D12);
  wire [11:0] lut_idx = share ? acq_data : idx_sep;
  pcp_mem #(.WIDTH(12), .DEPTH(`PCP_LUT_DEPTH), .AW(12)) u_lut (
    .hclk(hclk),
    .we(wr_ldata),
    .waddr(lut_addr[11:0]),
    .wdata(hwdata[11:0]),
    .raddr(lut_idx),
    .rdata(lut_q)
  );
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      deep_links <= 4'h0;
    end else if (acq_valid) begin
      deep_links[acq_link] <= (acq_depth == PCP_D12);
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      acq_valid_d <= 1'b0;
      acq_data_d <= 12'h0;
      acq_link_d <= 2'h0;
      depth_d <= 2'h0;
      acq_out_valid <= 1'b0;
      acq_out_data <= 12'h0;
      acq_out_link <= 2'h0;
    end else begin
      acq_valid_d <= acq_valid;
      acq_data_d <= acq_data;
      acq_link_d <= acq_link;
      depth_d <= acq_depth;
      acq_out_valid <= acq_valid_d;
      acq_out_link <= acq_link_d;
      case (depth_d)
        PCP_D8: acq_out_data <= {4'h0, lut_q[7:0]};
        PCP_D10: acq_out_data <= {2'h0, lut_q[9:0]};
        PCP_D12: acq_out_data <= lut_q;
        default: acq_out_data <= acq_data_d;
      endcase
    end
  end
  // ----------------------------------------------------------------
  // Formatter: subsample and mirror
  // ----------------------------------------------------------------
  wire flipx = ctrl[`PCP_CTRL_FLIPX];
  wire flipy = ctrl[`PCP_CTRL_FLIPY];
  wire [3:0] sx = scale[3:0];
  wire [3:0] sy = scale[11:8];
  wire [10:0] width = geom[10:0];
  wire [10:0] height = geom[26:16];
  pcp_src_type src;
  pcp_dst_type dst;
  assign src = pcp_src_type'(fmt[1:0]);
  assign dst = pcp_dst_type'(fmt[6:4]);
  logic [3:0] cx, cy;
  logic [10:0] col, lines_out;
  // A line start restarts the column phase, a frame start the row phase,
  // so leftovers of a short line or frame never drop the first pixel.
  wire [3:0] row_ph = (mem_sof | (cy == sy)) ? 4'h0 : cy + 4'h1;
  wire [3:0] cur_cy = mem_sol ? row_ph : cy;
  wire [3:0] cur_cx = mem_sol ? 4'h0 : cx;
  wire [10:0] cur_col = mem_sol ? 11'h0 : col;
  wire keep = mem_valid & (cur_cx == 4'h0) & (cur_cy == 4'h0);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cx <= 4'h0;
      cy <= 4'h0;
      col <= 11'h0;
      lines_out <= 11'h0;
    end else if (mem_valid) begin
      // Factor register holds factor minus one, giving 1 to 16.
      cx <= (cur_cx == sx) ? 4'h0 : cur_cx + 4'h1;
      cy <= cur_cy;
      if (mem_sof) begin
        lines_out <= 11'h0;
      end else if (mem_sol & (row_ph == 4'h0)) begin
        lines_out <= lines_out + 11'h1;
      end
      if (keep) col <= cur_col + 11'h1;
      else if (mem_sol) col <= 11'h0;
    end
  end
  // Horizontal mirror through a line buffer; vertical mirror written as
  // a destination-line index, since whole frames are not buffered here.
  logic [47:0] line_q;
  logic [10:0] wcol;
  logic lbank, out_v0;
  logic [10:0] line_idx;
  wire [10:0] mirror_col = width - 11'h1 - cur_col;
  assign wcol = flipx ? mirror_col : cur_col;
  pcp_mem #(.WIDTH(48), .DEPTH(`PCP_LINE_MAX), .AW(11)) u_line (
    .hclk(hclk),
    .we(keep),
    .waddr(wcol),
    .wdata(mem_data),
    .raddr(cur_col),
    .rdata(line_q)
  );
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      out_v0 <= 1'b0;
      line_idx <= 11'h0;
      lbank <= 1'b0;
    end else begin
      out_v0 <= keep;
      lbank <= lbank ^ (mem_valid & mem_sol);
      line_idx <= flipy ? height - 11'h1 - lines_out : lines_out;
    end
  end
  // Without flipx, the pixel passes straight; with it, the buffer.
  logic [47:0] px_d;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) px_d <= 48'h0;
    else px_d <= mem_data;
  end
  wire [47:0] px = flipx ? line_q : px_d;
  // ----------------------------------------------------------------
  // Colour conversion
  // ----------------------------------------------------------------
  // BGR24 uses depth 8; BGR48 uses depth 16 and a shift of 8.
  wire deep = (src == PCP_SRC_BGR48);
  wire [15:0] cb = deep ? px[15:0] : {8'h0, px[7:0]};
  wire [15:0] cg = deep ? px[31:16] : {8'h0, px[15:8]};
  wire [15:0] cr = deep ? px[47:32] : {8'h0, px[23:16]};
  wire [26:0] half = deep ? 27'h000_8000 : 27'h000_0080;
  // Coefficients scaled by 256; sums kept signed and wide.
  wire signed [27:0] ys = $signed({1'b0, 27'(cb * `PCP_KYB)})
    + $signed({1'b0, 27'(cg * `PCP_KYG)})
    + $signed({1'b0, 27'(cr * `PCP_KYR)});
  wire signed [27:0] us = $signed({1'b0, 27'(cb * `PCP_KUB)})
    - $signed({1'b0, 27'(cg * `PCP_KUG)})
    - $signed({1'b0, 27'(cr * `PCP_KUR)})
    + $signed({1'b0, 27'(half << 8)});
  wire signed [27:0] vs = $signed({1'b0, 27'(cr * `PCP_KVR)})
    - $signed({1'b0, 27'(cg * `PCP_KVG)})
    - $signed({1'b0, 27'(cb * `PCP_KVB)})
    + $signed({1'b0, 27'(half << 8)});
  function automatic logic [7:0] clamp8(input logic signed [27:0] v,
                                         input logic dp);
    logic signed [27:0] s;
    s = dp ? (v >>> 16) : (v >>> 8);
    if (s < 0) clamp8 = 8'h00;
    else if (s > 28'sd255) clamp8 = 8'hFF;
    else clamp8 = s[7:0];
  endfunction
  wire [7:0] y8 = clamp8(ys, deep);
  wire [7:0] u8 = clamp8(us, deep);
  wire [7:0] v8 = clamp8(vs, deep);
  logic xodd;
  logic [47:0] conv;
  always_comb begin
    conv = px;
    case (dst)
      PCP_DST_YUV: conv = {32'h0, y8, xodd ? v8 : u8};
      PCP_DST_MONO: conv = {40'h0, y8};
      PCP_DST_BGR: conv = (src == PCP_SRC_MONO8) ?
        {24'h0, px[7:0], px[7:0], px[7:0]} : px;
      PCP_DST_BGRA: conv = {16'h0, 8'hFF, px[23:0]};
      default: conv = px;
    endcase
  end
  // Chroma order restarts at every frame so U always leads.
  logic odd_next;
  wire par = mem_sof ? 1'b0 : odd_next;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      xodd <= 1'b0;
      odd_next <= 1'b0;
    end else if (keep) begin
      xodd <= par;
      odd_next <= ~par;
    end
  end
  // ----------------------------------------------------------------
  // Bayer 2x2 demosaic
  // ----------------------------------------------------------------
  // The previous row's pixels come from a one-line delay of samples.
  logic [7:0] left, up, upleft;
  logic [10:0] bcol;
  logic brow;
  wire [7:0] here = conv[7:0];
  wire [1:0] phase = ctrl[`PCP_CTRL_PHASE_HI:`PCP_CTRL_PHASE_LO];
  wire [1:0] pos = {brow, bcol[0]} ^ phase;
  wire [8:0] gsum = (pos == 2'h0 || pos == 2'h3) ?
    {1'b0, here} + {1'b0, upleft} : {1'b0, left} + {1'b0, up};
  wire [7:0] gavg = gsum[8:1];
  wire [7:0] bv = (pos == 2'h1) ? here : (pos == 2'h2) ? upleft :
    (pos == 2'h0) ? left : up;
  wire [7:0] rv = (pos == 2'h2) ? here : (pos == 2'h1) ? upleft :
    (pos == 2'h0) ? up : left;
  pcp_mem #(.WIDTH(8), .DEPTH(`PCP_LINE_MAX), .AW(11)) u_prev (
    .hclk(hclk),
    .we(out_v0),
    .waddr(bcol),
    .wdata(here),
    .raddr(bcol),
    .rdata(up)
  );
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      left <= 8'h0;
      upleft <= 8'h0;
      bcol <= 11'h0;
      brow <= 1'b0;
      dma_valid <= 1'b0;
      dma_data <= 48'h0;
    end else begin
      if (out_v0) begin
        left <= here;
        upleft <= up;
        bcol <= bcol + 11'h1;
      end
      if (mem_valid & mem_sol) begin
        bcol <= 11'h0;
        brow <= mem_sof ? 1'b0 : ~brow;
      end
      dma_valid <= out_v0;
      if (ctrl[`PCP_CTRL_BAYER_EN]) begin
        dma_data <= {24'h0, bv, gavg, rv};
      end else begin
        dma_data <= conv;
      end
    end
  end
endmodule

// [sim/pcp_top_props.sv]
// Port checker for the pixel conversion pipeline
`timescale 1ns/1ps
`include "pcp_defs.svh"
module pcp_top_props (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [1:0] acq_link,
  input wire logic acq_valid,
  input wire logic [11:0] acq_data,
  input wire logic acq_out_valid,
  input wire logic [11:0] acq_out_data,
  input wire logic [1:0] acq_out_link,
  input wire logic mem_valid,
  input wire logic mem_sof,
  input wire logic [47:0] mem_data,
  input wire logic dma_valid,
  input wire logic [47:0] dma_data
);
  import pcp_pkg::*;
  // ----
  // Shadow of the configuration, rebuilt from bus writes
  // ----
  logic wp;
  logic [31:0] wa, ctrl, scale, fmt;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wp <= 1'b0;
      wa <= 32'h0;
    end else if (hready) begin
      wp <= hsel & htrans[1] & hwrite;
      wa <= haddr;
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl <= `PCP_CTRL_RESET;
      scale <= `PCP_SCALE_RESET;
      fmt <= `PCP_FMT_RESET;
    end else if (wp && hready) begin
      if (wa == `PCP_OFF_CTRL) ctrl <= hwdata;
      if (wa == `PCP_OFF_SCALE) scale <= hwdata;
      if (wa == `PCP_OFF_FMT) fmt <= hwdata;
    end
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Bench holds the configuration still while pixels are in flight
  acq_lat_a: assert property (
    acq_valid |-> ##2 acq_out_valid) else $error("sample lost");
  acq_link_a: assert property (
    acq_valid |-> ##2 acq_out_link == $past(acq_link, 2))
    else $error("link changed");
  acq_cause_a: assert property (
    acq_out_valid |-> $past(acq_valid, 2)) else $error("stray sample");
  acq_ident_a: assert property (
    acq_valid && ctrl[7:6] == 2'h3 |->
    ##2 acq_out_data == $past(acq_data, 2)) else $error("not identity");
  dma_cause_a: assert property (
    dma_valid |-> $past(mem_valid, 2)) else $error("stray pixel");
  dma_sof_a: assert property (
    mem_valid && mem_sof |-> ##2 dma_valid) else $error("first dropped");
  sub_one_a: assert property (
    mem_valid && scale[3:0] == 4'h0 && scale[11:8] == 4'h0 |->
    ##2 dma_valid) else $error("pixel dropped");
  same_pass_a: assert property (
    mem_valid && scale[11:0] == 12'h0 && ctrl[2:0] == 3'h0 &&
    fmt[6:4] == PCP_DST_SAME |-> ##2 dma_data == $past(mem_data, 2))
    else $error("pixel altered");
  cover property (dma_valid && fmt[6:4] == PCP_DST_YUV);
  cover property (acq_out_valid && ctrl[7:6] == 2'h2);
  cover property (mem_valid && scale[11:0] != 12'h0);
endmodule
bind pcp_top pcp_top_props u_props (.hclk(hclk), .hresetn(hresetn),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hwdata(hwdata), .hready(hready), .acq_link(acq_link),
  .acq_valid(acq_valid), .acq_data(acq_data),
  .acq_out_valid(acq_out_valid), .acq_out_data(acq_out_data),
  .acq_out_link(acq_out_link), .mem_valid(mem_valid), .mem_sof(mem_sof),
  .mem_data(mem_data), .dma_valid(dma_valid), .dma_data(dma_data));

// [sim/pcp_mem_model.sv]
// Memory-side pixel source feeding the output formatter
`timescale 1ns/1ps
module pcp_mem_model (
  input wire logic hclk,
  input wire logic go,
  input wire logic slow,
  input wire logic [7:0] w,
  input wire logic [7:0] h,
  output logic idle,
  output logic mem_valid,
  output logic mem_sol,
  output logic mem_sof,
  output logic [47:0] mem_data
);
  integer seed = 32'h889E8885;
  logic [63:0] r;
  initial begin
    idle = 1'b1;
    mem_valid = 1'b0;
    mem_sol = 1'b0;
    mem_sof = 1'b0;
    mem_data = 48'h0;
    forever begin
      @(posedge hclk);
      if (go) begin
        idle <= 1'b0;
        for (int y = 0; y < h; y++) begin
          for (int x = 0; x < w; x++) begin
            r = {$random(seed), $random(seed)};
            mem_valid <= 1'b1;
            mem_sol <= x == 0;
            mem_sof <= x == 0 && y == 0;
            mem_data <= r[47:0];
            @(posedge hclk);
            // Stalls model a busy memory; idle data never repeats a pixel
            if (slow && r[60]) begin
              mem_valid <= 1'b0;
              mem_sol <= 1'b0;
              mem_sof <= 1'b0;
              mem_data <= ~r[47:0];
              @(posedge hclk);
            end
          end
        end
        mem_valid <= 1'b0;
        mem_sol <= 1'b0;
        mem_sof <= 1'b0;
        mem_data <= ~r[47:0];
        idle <= 1'b1;
      end
    end
  end
endmodule

// [sim/pixel_conversion_pipeline_tb_top.sv]
// Self-checking bench for the pixel conversion pipeline
`timescale 1ns/1ps
`include "pcp_defs.svh"
module pixel_conversion_pipeline_tb_top;
  import pcp_pkg::*;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, go, slow;
  logic acq_valid, acq_out_valid, mem_valid, mem_sol, mem_sof;
  logic dma_valid, idle, uv;
  logic [31:0] haddr, hwdata, hrdata, rv;
  logic [1:0] htrans, acq_link, acq_out_link, src, l;
  logic [2:0] hsize, dst;
  logic [11:0] acq_data, acq_out_data, s;
  logic [47:0] mem_data, dma_data;
  logic [7:0] w, h;
  logic [47:0] q[$];
  int fail_count, cmp_count, fx, fy, xc, yc, i, d;
  integer seed = 32'h889E8885;
  assign hready = hreadyout;
  pcp_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .acq_link(acq_link), .acq_valid(acq_valid), .acq_data(acq_data),
    .acq_out_valid(acq_out_valid), .acq_out_data(acq_out_data),
    .acq_out_link(acq_out_link), .mem_valid(mem_valid), .mem_sol(mem_sol),
    .mem_sof(mem_sof), .mem_data(mem_data), .dma_valid(dma_valid),
    .dma_data(dma_data));
  pcp_mem_model partner (.hclk(hclk), .go(go), .slow(slow), .w(w), .h(h),
    .idle(idle), .mem_valid(mem_valid), .mem_sol(mem_sol),
    .mem_sof(mem_sof), .mem_data(mem_data));
  initial begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end
  // ----
  // Expectations
  // ----
  function automatic logic [11:0] lut(input int k);
    return 12'(k * 37 + 5);
  endfunction
  function automatic logic [11:0] aexp(input int dp, input logic [11:0] v);
    if (dp == 3) return v;
    if (dp == 2) return lut(v);
    return lut({l, v[9:0]}) & (dp == 0 ? 12'h0FF : 12'h3FF);
  endfunction
  function automatic logic [7:0] yuv(input logic [47:0] p, input int k);
    int b, g, r, t, dp;
    dp = src == PCP_SRC_BGR48 ? 16 : 8;
    b = dp == 16 ? p[15:0] : p[7:0];
    g = dp == 16 ? p[31:16] : p[15:8];
    r = dp == 16 ? p[47:32] : p[23:16];
    t = 256 << (dp - 1);
    if (k == 0) t = `PCP_KYB * b + `PCP_KYG * g + `PCP_KYR * r;
    else if (k == 1) t = t + `PCP_KUB * b - `PCP_KUG * g - `PCP_KUR * r;
    else t = t - `PCP_KVB * b - `PCP_KVG * g + `PCP_KVR * r;
    t = t >>> dp;
    return t < 0 ? 8'h00 : t > 255 ? 8'hFF : 8'(t);
  endfunction
  function automatic logic [47:0] pexp(input logic [47:0] p);
    if (dst == PCP_DST_BGRA) return {16'h0, 8'hFF, p[23:0]};
    if (dst == PCP_DST_MONO) return {40'h0, yuv(p, 0)};
    if (dst != PCP_DST_YUV) return p;
    return {32'h0, yuv(p, 0), yuv(p, uv ? 2 : 1)};
  endfunction
  // ----
  // Drivers
  // ----
  task automatic chk(input string n, input logic [47:0] e, v);
    cmp_count++;
    if (v !== e) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", n, e, v);
    end
  endtask
  task automatic await(ref logic f, input int lim);
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (f !== 1'b1 && n < lim);
    if (f !== 1'b1) begin
      fail_count++;
      end_sim;
    end
  endtask
  task automatic bus(input logic wr, input logic [31:0] a, dt);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= a;
    hsize <= 3'h2;
    await(hready, 20);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= dt;
    await(hready, 20);
    rv = hrdata;
  endtask
  task automatic rchk(input logic [31:0] a, e);
    bus(1'b0, a, 32'h0);
    chk("register", e, rv);
    chk("response", 48'h0, {47'h0, hresp});
  endtask
  task automatic acq(input logic [11:0] e);
    acq_valid <= 1'b1;
    acq_link <= l;
    acq_data <= s;
    @(posedge hclk);
    acq_valid <= 1'b0;
    acq_data <= ~s;
    await(acq_out_valid, 8);
    chk("acq data", e, acq_out_data);
    chk("acq link", l, acq_out_link);
  endtask
  task automatic runf(input logic [1:0] sr, input logic [2:0] t,
    input int x, y, input logic sl, input logic [7:0] wd, ht);
    bus(1'b1, `PCP_OFF_FMT, {25'h0, t, 2'h0, sr});
    bus(1'b1, `PCP_OFF_SCALE, 32'((y - 1) << 8 | (x - 1)));
    src = sr;
    dst = t;
    fx = x;
    fy = y;
    slow <= sl;
    w <= wd;
    h <= ht;
    go <= 1'b1;
    @(posedge hclk);
    go <= 1'b0;
    @(posedge hclk);
    await(idle, 9000);
    repeat (4) @(posedge hclk);
    chk("pixels left", 48'h0, 48'(q.size()));
  endtask
  task automatic end_sim;
    $display("mismatches %0d comparisons %0d", fail_count, cmp_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // Counts positions as the formatter sees them; keeps the first of a group
  always @(posedge hclk) begin
    if (mem_valid === 1'b1) begin
      xc = mem_sol ? 0 : xc + 1;
      yc = mem_sof ? 0 : mem_sol ? yc + 1 : yc;
      uv = mem_sof ? 1'b0 : uv;
      if (xc % fx == 0 && yc % fy == 0) begin
        q.push_back(pexp(mem_data));
        uv = ~uv;
      end
    end
    if (dma_valid === 1'b1 && q.size() == 0) begin
      chk("extra pixel", 48'h0, 48'h1);
    end else if (dma_valid === 1'b1) begin
      chk("pixel", q.pop_front(), dst == PCP_DST_YUV ?
        dma_data & 48'hFFFF : dma_data);
    end
  end
  initial begin
    {hresetn, hsel, haddr, htrans, hwrite, hsize, hwdata} = '0;
    {acq_valid, acq_link, acq_data, go, slow, w, h, uv} = '0;
    {src, dst, xc, yc, fail_count, cmp_count} = '0;
    fx = 1;
    fy = 1;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rchk(`PCP_OFF_CTRL, `PCP_CTRL_RESET);
    rchk(`PCP_OFF_SCALE, `PCP_SCALE_RESET);
    rchk(`PCP_OFF_FMT, `PCP_FMT_RESET);
    rchk(`PCP_OFF_GEOM, `PCP_GEOM_RESET);
    rchk(32'h0000_0040, 32'h0);
    bus(1'b1, `PCP_OFF_SCALE, 32'h0000_0F0F);
    rchk(`PCP_OFF_SCALE, 32'h0000_0F0F);
    bus(1'b1, `PCP_OFF_LUTADDR, 32'h0);
    for (i = 0; i < `PCP_LUT_DEPTH; i++) begin
      bus(1'b1, `PCP_OFF_LUTDATA, {20'h0, lut(i)});
    end
    for (d = 0; d < 4; d++) begin
      bus(1'b1, `PCP_OFF_CTRL, 32'(d << 6));
      for (i = 0; i < 30; i++) begin
        l = 2'($random(seed));
        s = i == 0 ? 12'hFFF : 12'($random(seed));
        s = s & (d == 0 ? 12'h0FF : d == 1 ? 12'h3FF : 12'hFFF);
        acq(aexp(d, s));
      end
    end
    runf(PCP_SRC_BGR48, PCP_DST_SAME, 1, 1, 1'b0, 8'd6, 8'd3);
    runf(PCP_SRC_BGR48, PCP_DST_SAME, 2, 3, 1'b1, 8'd7, 8'd7);
    runf(PCP_SRC_BGR24, PCP_DST_SAME, 16, 16, 1'b1, 8'd33, 8'd17);
    runf(PCP_SRC_BGR24, PCP_DST_YUV, 1, 1, 1'b1, 8'd6, 8'd4);
    runf(PCP_SRC_BGR48, PCP_DST_YUV, 1, 1, 1'b0, 8'd6, 8'd4);
    runf(PCP_SRC_BGR24, PCP_DST_MONO, 3, 2, 1'b1, 8'd9, 8'd5);
    runf(PCP_SRC_BGR24, PCP_DST_BGRA, 1, 1, 1'b0, 8'd5, 8'd3);
    end_sim;
  end
endmodule
